// ### pci_pkg.sv
// Package for the pin change interrupt block: register map, field layout, reset values.
// Assumes an APB slave with 32-bit data; each register takes one aligned word.
package pci_pkg;
    localparam int PCI_NPINS = 6;
    localparam int PCI_AW = 8;
    localparam logic [7:0] PCI_OFF_RISE = 8'h00;
    localparam logic [7:0] PCI_OFF_FALL = 8'h04;
    localparam logic [7:0] PCI_OFF_FLAG = 8'h08;
    localparam logic [7:0] PCI_OFF_CTRL = 8'h0C;
    localparam logic [7:0] PCI_OFF_STAT = 8'h10;
    localparam logic [7:0] PCI_OFF_IEN = 8'h14;
    localparam logic [7:0] PCI_OFF_ICLR = 8'h18;
    localparam int PCI_CTRL_MEN_BIT = 0;
    localparam int PCI_STAT_SUM_BIT = 0;
    localparam logic [5:0] PCI_RST_EN = 6'h00;
    localparam logic [5:0] PCI_RST_FLAG = 6'h00;
    localparam logic [1:0] PCI_RST_EVT = 2'h0;
    localparam int PCI_EVT_EDGE = 0;
    localparam int PCI_EVT_WAKE = 1;

    typedef struct packed {
        logic [PCI_AW-1:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } pci_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } pci_apb_rsp_s;
endpackage

// ### pci_pin_change_irq.sv
// Pin change interrupt logic for one six-pin port with APB register access.
// Assumes pins are asynchronous to pclk; one clock domain; APB master per AMBA.
//
// Contract
// - Each pin has rising and falling detectors
// - Each direction gated by its enable bit
// - Both enables set detects both directions
// - Enabled edge sets flag, irq if master
// - Master clear: flags still set, no irq
// - Summary flag is OR of all flags
// - Writing zero clears a flag bit
// - Edge during flag write keeps flag set
// - Change event wakes sleep only if enabled
// - Rising enables bits 5:0, upper read zero
// - Cleared rising enable sets no flag
// - Falling enables bits 5:0, upper read zero
// - Flags set by enabled rising/falling edges
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ps
module pci_pin_change_irq
    import pci_pkg::*;
#(
    parameter int NPINS = PCI_NPINS
)(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire pci_apb_req_s apb_req,
    output pci_apb_rsp_s apb_rsp,
    // Port pins and system
    input wire logic [NPINS-1:0] porta_pin,
    input wire logic sleep_active,
    output logic change_irq,
    output logic wake_req,
    output logic change_irq_summary_flag
);
    // Reset values and register fields are only six bits wide
    if (NPINS < 1 || NPINS > PCI_NPINS)
    begin : g_npins_check
        $error("NPINS must be 1 to 6");
    end

    function automatic logic [31:0] pci_zext(input logic [NPINS-1:0] v);
        logic [31:0] r;
        r = 32'h0;
        r[NPINS-1:0] = v;
        return r;
    endfunction

    // Three-stage sync: first stage only feeds the second
    logic [NPINS-1:0] sync1, sync2, sync3;
    logic [NPINS-1:0] next_sync1, next_sync2, next_sync3;
    logic [NPINS-1:0] rise_pulse, fall_pulse;
    logic [NPINS-1:0] porta_rising_edge_enable, porta_falling_edge_enable, porta_change_flags;
    logic [NPINS-1:0] next_rise_en, next_fall_en, next_flags;
    logic change_irq_master_enable, next_master_en;
    logic [1:0] evt_stat, evt_ien, next_evt_stat, next_evt_ien;
    logic next_irq, next_wake, next_sum;
    pci_apb_rsp_s next_rsp;
    logic wr_acc, rd_acc;
    logic [NPINS-1:0] det;
    logic [1:0] evt_set;
    logic [NPINS-1:0] level, next_level;

    always_comb
    begin
        next_sync1 = porta_pin;
        next_sync2 = sync1;
        next_sync3 = sync2;
        // A change counts once stages two and three disagree with the held level
        rise_pulse = sync2 & sync3 & ~level;
        fall_pulse = ~sync2 & ~sync3 & level;
    end

    always_comb
    begin
        next_level = level;
        for (int i = 0; i < NPINS; i++)
        begin
            if (sync2[i] == sync3[i])
                next_level[i] = sync3[i];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            level <= '0;
        end
        else
        begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            sync3 <= next_sync3;
            level <= next_level;
        end
    end

    // Enabled detection per direction; both enables give both edges
    assign det = (rise_pulse & porta_rising_edge_enable)
               | (fall_pulse & porta_falling_edge_enable);

    assign wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign rd_acc = apb_req.psel && !apb_req.penable && !apb_req.pwrite;

    // Register and flag next state
    always_comb
    begin
        next_rise_en = porta_rising_edge_enable;
        next_fall_en = porta_falling_edge_enable;
        next_flags = porta_change_flags;
        next_master_en = change_irq_master_enable;
        next_evt_ien = evt_ien;
        next_evt_stat = evt_stat;
        if (wr_acc)
        begin
            case (apb_req.paddr)
                PCI_OFF_RISE: next_rise_en = apb_req.pwdata[NPINS-1:0];
                PCI_OFF_FALL: next_fall_en = apb_req.pwdata[NPINS-1:0];
                PCI_OFF_FLAG: next_flags = apb_req.pwdata[NPINS-1:0] & porta_change_flags;
                PCI_OFF_CTRL: next_master_en = apb_req.pwdata[PCI_CTRL_MEN_BIT];
                PCI_OFF_IEN: next_evt_ien = apb_req.pwdata[1:0];
                PCI_OFF_ICLR: next_evt_stat = evt_stat & ~apb_req.pwdata[1:0];
                default: ;
            endcase
        end
        // Hardware set wins over any write in the same cycle
        next_flags = next_flags | det;
        evt_set[PCI_EVT_EDGE] = |det;
        evt_set[PCI_EVT_WAKE] = |det && change_irq_master_enable && sleep_active;
        next_evt_stat = next_evt_stat | evt_set;
        next_sum = |next_flags;
        // Master enable gates every request, events included; flags keep collecting
        next_irq = next_master_en && (next_sum || |(next_evt_stat & next_evt_ien));
        next_wake = next_sum && next_master_en && sleep_active;
    end

    // Read data is registered in setup so the access phase answers at once
    always_comb
    begin
        next_rsp = '0;
        next_rsp.pready = 1'b1;
        if (apb_req.psel && !apb_req.penable)
        begin
            next_rsp.prdata = apb_rsp.prdata;
            if (rd_acc)
            begin
                case (apb_req.paddr)
                    PCI_OFF_RISE: next_rsp.prdata = pci_zext(porta_rising_edge_enable);
                    PCI_OFF_FALL: next_rsp.prdata = pci_zext(porta_falling_edge_enable);
                    PCI_OFF_FLAG: next_rsp.prdata = pci_zext(porta_change_flags);
                    PCI_OFF_CTRL: next_rsp.prdata = {31'h0, change_irq_master_enable};
                    PCI_OFF_STAT: next_rsp.prdata = {31'h0, change_irq_summary_flag};
                    PCI_OFF_IEN: next_rsp.prdata = {30'h0, evt_ien};
                    PCI_OFF_ICLR: next_rsp.prdata = {30'h0, evt_stat};
                    default: next_rsp.prdata = 32'h0;
                endcase
            end
            next_rsp.pslverr = !(apb_req.paddr inside {PCI_OFF_RISE, PCI_OFF_FALL,
                PCI_OFF_FLAG, PCI_OFF_CTRL, PCI_OFF_STAT, PCI_OFF_IEN, PCI_OFF_ICLR});
        end
        else
        begin
            next_rsp.prdata = apb_rsp.prdata;
            next_rsp.pslverr = apb_rsp.pslverr;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            porta_rising_edge_enable <= PCI_RST_EN[NPINS-1:0];
            porta_falling_edge_enable <= PCI_RST_EN[NPINS-1:0];
            porta_change_flags <= PCI_RST_FLAG[NPINS-1:0];
            change_irq_master_enable <= 1'b0;
            evt_stat <= PCI_RST_EVT;
            evt_ien <= PCI_RST_EVT;
            change_irq <= 1'b0;
            wake_req <= 1'b0;
            change_irq_summary_flag <= 1'b0;
            apb_rsp <= '{prdata: 32'h0, pready: 1'b1, pslverr: 1'b0};
        end
        else
        begin
            porta_rising_edge_enable <= next_rise_en;
            porta_falling_edge_enable <= next_fall_en;
            porta_change_flags <= next_flags;
            change_irq_master_enable <= next_master_en;
            evt_stat <= next_evt_stat;
            evt_ien <= next_evt_ien;
            change_irq <= next_irq;
            wake_req <= next_wake;
            change_irq_summary_flag <= next_sum;
            apb_rsp <= next_rsp;
        end
    end

    // Pins that moved in a direction they may not report, or with both directions on
    logic [NPINS-1:0] rise_blocked, fall_blocked, both_hit;
    assign rise_blocked = rise_pulse & ~porta_rising_edge_enable & ~porta_change_flags;
    assign fall_blocked = fall_pulse & ~porta_falling_edge_enable & ~porta_change_flags;
    assign both_hit = (rise_pulse | fall_pulse)
                    & porta_rising_edge_enable & porta_falling_edge_enable;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_flag_set;
        |det |=> (porta_change_flags & $past(det)) == $past(det);
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set");

    property p_flag_write_keeps;
        (wr_acc && apb_req.paddr == PCI_OFF_FLAG && |det)
            |=> (porta_change_flags & $past(det)) == $past(det);
    endproperty
    a_flag_write_keeps: assert property (p_flag_write_keeps) else $error("edge lost");

    property p_clear;
        (wr_acc && apb_req.paddr == PCI_OFF_FLAG && !apb_req.pwdata[0] && !det[0])
            |=> !porta_change_flags[0];
    endproperty
    a_clear: assert property (p_clear) else $error("clear failed");

    property p_rise_gate;
        |rise_blocked |=> (porta_change_flags & $past(rise_blocked)) == '0;
    endproperty
    a_rise_gate: assert property (p_rise_gate) else $error("disabled rise set flag");

    property p_fall_gate;
        |fall_blocked |=> (porta_change_flags & $past(fall_blocked)) == '0;
    endproperty
    a_fall_gate: assert property (p_fall_gate) else $error("disabled fall set flag");

    property p_rise_det;
        (!sync3[0] && !level[0] ##1 sync3[0] && sync2[0]) |-> rise_pulse[0];
    endproperty
    a_rise_det: assert property (p_rise_det) else $error("rise missed");

    property p_fall_det;
        (sync3[0] && level[0] ##1 !sync3[0] && !sync2[0]) |-> fall_pulse[0];
    endproperty
    a_fall_det: assert property (p_fall_det) else $error("fall missed");

    property p_rise_once;
        rise_pulse[0] |=> !rise_pulse[0];
    endproperty
    a_rise_once: assert property (p_rise_once) else $error("rise pulse too long");

    property p_summary;
        ##1 change_irq_summary_flag == (|porta_change_flags);
    endproperty
    a_summary: assert property (p_summary) else $error("summary wrong");

    property p_no_irq_masked;
        !change_irq_master_enable |-> !change_irq;
    endproperty
    a_no_irq_masked: assert property (p_no_irq_masked) else $error("irq while off");

    property p_irq_on;
        (change_irq_master_enable && change_irq_summary_flag) |-> change_irq;
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("irq missing");

    property p_both_dir;
        |both_hit |=> (porta_change_flags & $past(both_hit)) == $past(both_hit);
    endproperty
    a_both_dir: assert property (p_both_dir) else $error("both-way pin lost edge");

    property p_flags_hold;
        (det == '0 && !(wr_acc && apb_req.paddr == PCI_OFF_FLAG))
            |=> $stable(porta_change_flags);
    endproperty
    a_flags_hold: assert property (p_flags_hold) else $error("flag moved alone");

    property p_wake;
        wake_req |-> change_irq_master_enable && change_irq_summary_flag;
    endproperty
    a_wake: assert property (p_wake) else $error("bad wake");

    property p_upper_zero;
        ##1 (apb_rsp.prdata[31:NPINS] == '0 || !$past(apb_req.paddr == PCI_OFF_RISE));
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");

    property p_rise_wr;
        (wr_acc && apb_req.paddr == PCI_OFF_RISE)
            |=> porta_rising_edge_enable == $past(apb_req.pwdata[NPINS-1:0]);
    endproperty
    a_rise_wr: assert property (p_rise_wr) else $error("rise enable write lost");

    property p_fall_wr;
        (wr_acc && apb_req.paddr == PCI_OFF_FALL)
            |=> porta_falling_edge_enable == $past(apb_req.pwdata[NPINS-1:0]);
    endproperty
    a_fall_wr: assert property (p_fall_wr) else $error("fall enable write lost");

    c_flag: cover property (det[0] ##1 porta_change_flags[0]);
    c_irq: cover property (change_irq);
    c_wake: cover property (wake_req);
    c_race: cover property (wr_acc && apb_req.paddr == PCI_OFF_FLAG && |det);
    c_evt_irq: cover property (change_irq && !change_irq_summary_flag);
endmodule // pci_pin_change_irq

// ### pci_pin_src.sv
// Far-side model: external logic levels on the six port pins.
// Assumes the bench calls drive right after a clock edge.
`timescale 1ns/1ps
module pci_pin_src
    import pci_pkg::*;
(
    // Clock used only to place pin changes
    input wire logic pclk,
    // Port pins
    output logic [PCI_NPINS-1:0] porta_pin
);
    initial porta_pin = '0;

    // Pins move just after an edge; the design treats them as asynchronous anyway
    task automatic drive(input logic [PCI_NPINS-1:0] v);
        @(posedge pclk);
        porta_pin <= v;
    endtask
endmodule // pci_pin_src

// ### tb.sv
// Self-checking bench for the pin change interrupt block.
// Assumes flags follow a pin change four edges later; APB waits on pready.
`timescale 1ns/1ps
module tb
    import pci_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic sleep_active = 1'b0;
    pci_apb_req_s req = '0;
    pci_apb_rsp_s rsp;
    logic [5:0] pins;
    logic change_irq;
    logic wake_req;
    logic sum_flag;
    logic last_err;
    logic [31:0] rd;
    int fail_count = 0;
    int check_count = 0;
    int cyc = 0;

    always #2 pclk = ~pclk;

    pci_pin_change_irq u_pci_pin_change_irq (.pclk(pclk), .presetn(presetn), .apb_req(req),
        .apb_rsp(rsp), .porta_pin(pins), .sleep_active(sleep_active),
        .change_irq(change_irq), .wake_req(wake_req), .change_irq_summary_flag(sum_flag));
    pci_pin_src u_pci_pin_src (.pclk(pclk), .porta_pin(pins));

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Entered just after an edge; holds the request until pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
        @(posedge pclk);
        req.penable <= 1'b1;
        @(posedge pclk);
        while (rsp.pready !== 1'b1)
            @(posedge pclk);
        rd = rsp.prdata;
        last_err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, exp);
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic t_reset;
        rdc("rise_rst", PCI_OFF_RISE, 32'h0);
        rdc("fall_rst", PCI_OFF_FALL, 32'h0);
        rdc("flag_rst", PCI_OFF_FLAG, 32'h0);
        rdc("ctrl_rst", PCI_OFF_CTRL, 32'h0);
        rdc("unmapped", 8'h1C, 32'h0);
        chk("slverr", 32'(last_err), 32'h1);
        apb(1'b1, PCI_OFF_RISE, 32'hFF);
        rdc("rise_w", PCI_OFF_RISE, 32'h3F);
        apb(1'b1, PCI_OFF_FALL, 32'hFF);
        rdc("fall_w", PCI_OFF_FALL, 32'h3F);
        apb(1'b1, PCI_OFF_STAT, 32'h1);
        rdc("stat_ro", PCI_OFF_STAT, 32'h0);
    endtask

    task automatic t_edges;
        apb(1'b1, PCI_OFF_RISE, 32'h05);
        apb(1'b1, PCI_OFF_FALL, 32'h06);
        u_pci_pin_src.drive(6'h3F);
        wt(8);
        rdc("flag_rise", PCI_OFF_FLAG, 32'h05);
        chk("summary", 32'(sum_flag), 32'h1);
        rdc("stat_sum", PCI_OFF_STAT, 32'h1);
        chk("irq_off", 32'(change_irq), 32'h0);
        // Clear only what was seen, so a fresh edge survives
        apb(1'b1, PCI_OFF_FLAG, 32'h05 ^ 32'hFF);
        rdc("flag_clr", PCI_OFF_FLAG, 32'h0);
        chk("summary_clr", 32'(sum_flag), 32'h0);
        u_pci_pin_src.drive(6'h00);
        wt(8);
        rdc("flag_fall", PCI_OFF_FLAG, 32'h06);
        apb(1'b1, PCI_OFF_CTRL, 32'h1);
        wt(2);
        chk("irq_on", 32'(change_irq), 32'h1);
        chk("wake_awake", 32'(wake_req), 32'h0);
        sleep_active <= 1'b1;
        wt(3);
        chk("wake_sleep", 32'(wake_req), 32'h1);
        apb(1'b1, PCI_OFF_CTRL, 32'h0);
        wt(2);
        chk("wake_men_off", 32'(wake_req), 32'h0);
        chk("irq_men_off", 32'(change_irq), 32'h0);
        sleep_active <= 1'b0;
    endtask

    task automatic t_events;
        apb(1'b1, PCI_OFF_ICLR, 32'h3);
        apb(1'b1, PCI_OFF_FLAG, 32'h0);
        u_pci_pin_src.drive(6'h01);
        wt(8);
        chk("evt_masked", 32'(change_irq), 32'h0);
        rdc("evt_stat", PCI_OFF_ICLR, 32'h1);
        apb(1'b1, PCI_OFF_IEN, 32'h1);
        wt(2);
        chk("evt_men_off", 32'(change_irq), 32'h0);
        // With the flags gone only the event bit can hold the request up
        apb(1'b1, PCI_OFF_FLAG, 32'h0);
        apb(1'b1, PCI_OFF_CTRL, 32'h1);
        wt(2);
        chk("evt_sum", 32'(sum_flag), 32'h0);
        chk("evt_irq", 32'(change_irq), 32'h1);
        apb(1'b1, PCI_OFF_ICLR, 32'h1);
        wt(2);
        chk("evt_irq_clr", 32'(change_irq), 32'h0);
        rdc("evt_clr", PCI_OFF_ICLR, 32'h0);
    endtask

    // Write lands on the very edge where the pin 2 flag is set
    task automatic t_race;
        sleep_active <= 1'b1;
        u_pci_pin_src.drive(6'h05);
        wt(1);
        apb(1'b1, PCI_OFF_FLAG, 32'h0);
        rdc("flag_race", PCI_OFF_FLAG, 32'h04);
        chk("wake_race", 32'(wake_req), 32'h1);
        rdc("evt_wake", PCI_OFF_ICLR, 32'h3);
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            fail_count++;
            close_out;
        end
    end

    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_edges;
        t_events;
        t_race;
        close_out;
    end
endmodule // tb
